// file: power_mode_pkg.sv
// Package: modes, carriers and timing constants of the power mode controller
`default_nettype none
package power_mode_pkg;

  // ****************
  // Modes
  // ****************
  typedef enum logic [1:0] {
    full_operation_mode = 2'h0,
    tamper_measure_mode = 2'h1,
    peak_detect_mode    = 2'h2,
    idle_mode           = 2'h3
  } power_mode_t;

  // ****************
  // Timing
  // ****************
  localparam int CLK_FREQ_MHZ       = 50;
  localparam int REG_OFF_DELAY_US   = 1;
  localparam int REG_OFF_CYCLES     = REG_OFF_DELAY_US * CLK_FREQ_MHZ;

  // ****************
  // Reset values, widths and threshold scale
  // ****************
  localparam int          PEAK_CFG_W       = 8;
  localparam int          PEAK_SAMPLE_W    = 16;
  localparam logic [7:0]  PEAK_CFG_DEFAULT = 8'h00;
  localparam int          THRESH_LSB_SHIFT = 8;

  // ****************
  // Carriers
  // ****************
  typedef struct packed {
    logic spiEnable;
    logic measureEnable;
    logic neutralAdcEnable;
    logic phaseAdcEnable;
    logic waveBufEnable;
    logic accumEnable;
    logic zeroCrossingEnable;
    logic peakDetectEnable;
  } func_enables_t;

  typedef struct packed {
    logic [PEAK_SAMPLE_W-1:0] phaseA;
    logic [PEAK_SAMPLE_W-1:0] phaseB;
    logic [PEAK_SAMPLE_W-1:0] phaseC;
  } phase_currents_t;

endpackage : power_mode_pkg
`default_nettype wire

// file: power_mode_controller.sv
// Module: pin-selected power mode controller with peak detect and clock gating
`default_nettype none

// How it works
// - Mode pins decoded continuously, no command
// - Pins 00 full, 01 tamper, 10 peak, 11 idle
// - Serial port only in full and tamper
// - Peak mode compares currents, flags interrupt pins
// - Peak config retained through peak and idle
// - Full or tamper entry from peak or idle resets peak config
// - Tamper mode disables neutral, buffer, accumulation
// - Inverted clock out only in full, tamper
// - External reference bit disables internal buffer
// - Regulators off after 1 us in low modes
// - Tamper neutral converter off; idle all off, peak only peak detect
module power_mode_controller
  import power_mode_pkg::*;
#(
  parameter int OFF_CYCLES = REG_OFF_CYCLES
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Mode pins from host
  input  wire logic                  mode_sel_hi_pin,
  input  wire logic                  mode_sel_lo_pin,
  // Peak detect configuration write
  input  wire logic                  peakCfgWrite,
  input  wire logic [PEAK_CFG_W-1:0] peakCfgData,
  input  wire logic                  external_reference_select,
  // Phase currents and clock input
  input  wire phase_currents_t       phaseCurrents,
  input  wire logic                  clock_in_pin,
  input  wire logic                  extClockSelect,
  // Status and controls
  output logic [1:0]                 powerMode,
  output func_enables_t              funcEnables,
  output logic [PEAK_CFG_W-1:0]      peak_detect_config,
  output logic                       regulatorsOn,
  output logic                       internalRefBufOn,
  output logic                       inverted_clock_out,
  output logic                       interrupt_out_a_n,
  output logic                       interrupt_out_b_n
);

  // Counter sized from the off delay so a faster clock cannot wrap it
  localparam int CNT_W = $clog2(OFF_CYCLES + 1);

  // ****************
  // Pin synchroniser
  // ****************
  logic [1:0] pinMeta_r, pinSync_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinMeta_r <= 2'h3;
      pinSync_r <= 2'h3;
    end else begin
      pinMeta_r <= {mode_sel_hi_pin, mode_sel_lo_pin};
      pinSync_r <= pinMeta_r;
    end
  end

  // ****************
  // Clock input synchroniser
  // ****************
  // Only slow clocks survive sampling at 50 MHz
  logic clkMeta_r, clkSync_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkMeta_r <= 1'b0;
      clkSync_r <= 1'b0;
    end else begin
      clkMeta_r <= clock_in_pin;
      clkSync_r <= clkMeta_r;
    end
  end

  // ****************
  // Mode state
  // ****************
  power_mode_t mode_r, mode_nxt;
  logic [PEAK_CFG_W-1:0] cfg_r, cfg_nxt;
  logic [CNT_W-1:0] lowCnt_r, lowCnt_nxt;
  logic        regOn_r, regOn_nxt;
  logic        irqA_r, irqA_nxt, irqB_r, irqB_nxt;
  logic        inverted_clock_out_r, inverted_clock_out_nxt;
  logic        extRef_r, extRef_nxt;

  // ****************
  // Helpers
  // ****************

  function automatic logic isActive(input power_mode_t m);
    return (m == full_operation_mode) || (m == tamper_measure_mode);
  endfunction : isActive

  function automatic logic overThresh(input logic [PEAK_SAMPLE_W-1:0] s,
                                      input logic [PEAK_CFG_W-1:0]    c);
    logic [PEAK_SAMPLE_W-1:0] mag;
    mag = s[PEAK_SAMPLE_W-1] ? PEAK_SAMPLE_W'(-s) : s;
    return mag > (PEAK_SAMPLE_W'(c) << THRESH_LSB_SHIFT);
  endfunction : overThresh

  always_comb begin
    mode_nxt   = power_mode_t'(pinSync_r);
    cfg_nxt    = cfg_r;
    lowCnt_nxt = lowCnt_r;
    regOn_nxt  = regOn_r;
    irqA_nxt   = irqA_r;
    irqB_nxt   = irqB_r;
    inverted_clock_out_nxt = 1'b0;
    extRef_nxt = extRef_r;
    // Retained through low modes; written only while port is up
    if (isActive(mode_nxt) && !isActive(mode_r)) begin
      cfg_nxt = PEAK_CFG_DEFAULT;
    end else if (peakCfgWrite && isActive(mode_r)) begin
      cfg_nxt = peakCfgData;
    end
    if (peakCfgWrite && isActive(mode_r)) begin
      extRef_nxt = external_reference_select;
    end

    // Brief glitches into low modes under 1 us keep regulators up
    if (isActive(mode_r)) begin
      lowCnt_nxt = '0;
      regOn_nxt  = 1'b1;
    end else if (regOn_r) begin
      if (32'(lowCnt_r) + 1 >= OFF_CYCLES) begin
        regOn_nxt = 1'b0;
      end else begin
        lowCnt_nxt = lowCnt_r + CNT_W'(1);
      end
    end

    case (mode_r)
      peak_detect_mode: begin
        irqA_nxt = !(overThresh(phaseCurrents.phaseA, cfg_r) ||
                     overThresh(phaseCurrents.phaseB, cfg_r));
        irqB_nxt = !overThresh(phaseCurrents.phaseC, cfg_r);
      end
      full_operation_mode, tamper_measure_mode: begin
        irqA_nxt   = 1'b1;
        irqB_nxt   = 1'b1;
        inverted_clock_out_nxt = extClockSelect && !clkSync_r;
      end
      default: begin
        irqA_nxt = 1'b1;
        irqB_nxt = 1'b1;
      end
    endcase
  end

  // ****************
  // Registers
  // ****************

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r   <= idle_mode;
      cfg_r    <= PEAK_CFG_DEFAULT;
      lowCnt_r <= '0;
      regOn_r  <= 1'b0;
      irqA_r   <= 1'b1;
      irqB_r   <= 1'b1;
      inverted_clock_out_r <= 1'b0;
      extRef_r <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      cfg_r    <= cfg_nxt;
      lowCnt_r <= lowCnt_nxt;
      regOn_r  <= regOn_nxt;
      irqA_r   <= irqA_nxt;
      irqB_r   <= irqB_nxt;
      inverted_clock_out_r <= inverted_clock_out_nxt;
      extRef_r <= extRef_nxt;
    end
  end

  // ****************
  // Function gating
  // ****************
  always_comb begin
    funcEnables = '0;
    case (mode_r)
      full_operation_mode: begin
        funcEnables = '1;
        funcEnables.peakDetectEnable = 1'b0;
      end
      tamper_measure_mode: begin
        funcEnables.spiEnable          = 1'b1;
        funcEnables.measureEnable      = 1'b1;
        funcEnables.phaseAdcEnable     = 1'b1;
        funcEnables.zeroCrossingEnable = 1'b1;
      end
      peak_detect_mode: begin
        funcEnables.peakDetectEnable = 1'b1;
      end
      default: begin
        funcEnables = '0;
      end
    endcase
  end

  // ****************
  // Outputs
  // ****************

  assign powerMode          = mode_r;
  assign peak_detect_config = cfg_r;
  assign regulatorsOn       = regOn_r;
  assign internalRefBufOn   = regOn_r && !extRef_r;
  assign inverted_clock_out = inverted_clock_out_r;
  assign interrupt_out_a_n  = irqA_r;
  assign interrupt_out_b_n  = irqB_r;

endmodule : power_mode_controller
`default_nettype wire

// file: host_pins.sv
// Host model: drives the two mode pins from a requested mode
`default_nettype none
module host_pins
  import power_mode_pkg::*;
(
  // Request and pins
  input  wire power_mode_t want,
  output logic             hiPin,
  output logic             loPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins follow the request as soon as the bench changes it
  assign {hiPin, loPin} = want;
endmodule : host_pins
`default_nettype wire

// file: mode_sva.sv
// Checker: power mode controller assertions
`default_nettype none
module mode_sva
  import power_mode_pkg::*;
(
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic            mode_sel_hi_pin,
  input wire logic            mode_sel_lo_pin,
  input wire logic [1:0]      powerMode,
  input wire func_enables_t   funcEnables,
  input wire logic [7:0]      peak_detect_config,
  input wire logic            regulatorsOn,
  input wire logic            inverted_clock_out,
  input wire logic            interrupt_out_a_n,
  input wire logic            interrupt_out_b_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] lowCnt_r;
  logic [6:0] lowCnt_nxt;
  wire        lowPwr = powerMode[1];
  // Saturates so a long idle spell cannot wrap back under the limit
  always_comb lowCnt_nxt = !lowPwr ? 7'h0 : lowCnt_r + {6'h0, lowCnt_r != 7'h7f};
  always_ff @(posedge clk) lowCnt_r <= sys_rst ? 7'h0 : lowCnt_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence pinsSteady;
    $stable(mode_sel_hi_pin) && $stable(mode_sel_lo_pin);
  endsequence
  sequence stayActive;
    !lowPwr ##1 !lowPwr;
  endsequence
  sequence enterActive;
    lowPwr ##1 !lowPwr;
  endsequence
  mode_decode_a: assert property (pinsSteady [*3]
    |=> powerMode == {$past(mode_sel_hi_pin), $past(mode_sel_lo_pin)}) else $error("mode decode");
  irq_quiet_a: assert property (powerMode != 2'h2 |=> interrupt_out_a_n && interrupt_out_b_n)
    else $error("irq quiet");
  spi_gate_a: assert property (funcEnables.spiEnable == !lowPwr) else $error("spi gate");
  func_set_a: assert property (funcEnables == (powerMode == 2'h0 ? 8'hfe :
    powerMode == 2'h1 ? 8'hd2 : {7'h0, powerMode == 2'h2})) else $error("func set");
  clk_gate_a: assert property (lowPwr && $past(lowPwr) |-> !inverted_clock_out)
    else $error("clock gate");
  cfg_keep_a: assert property (lowPwr && $past(lowPwr) |-> $stable(peak_detect_config))
    else $error("cfg keep");
  cfg_default_a: assert property (enterActive |-> peak_detect_config == PEAK_CFG_DEFAULT)
    else $error("cfg default");
  reg_on_a: assert property (stayActive |-> regulatorsOn) else $error("reg on");
  reg_off_a: assert property (lowCnt_r >= 7'(REG_OFF_CYCLES) |-> !regulatorsOn)
    else $error("reg off");
endmodule : mode_sva
`default_nettype wire

// file: test_power_mode_controller.sv
// Testbench: power mode controller scenarios
`default_nettype none
module test_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import power_mode_pkg::*;
  logic clk = 0, sys_rst = 1, peakCfgWrite = 0, external_reference_select = 0;
  logic clock_in_pin = 0, extClockSelect = 0, mode_sel_hi_pin, mode_sel_lo_pin;
  logic [7:0] peakCfgData = 8'h00, peak_detect_config;
  phase_currents_t phaseCurrents = '0;
  power_mode_t want = idle_mode;
  logic [1:0] powerMode;
  func_enables_t funcEnables;
  logic regulatorsOn, internalRefBufOn, inverted_clock_out, interrupt_out_a_n, interrupt_out_b_n;
  int nMismatch = 0, nChecks = 0, cyc = 0;
  localparam logic [7:0] TAB [4] = '{8'hfe, 8'hd2, 8'h01, 8'h00};
  power_mode_controller dut (
    .clk(clk), .sys_rst(sys_rst), .mode_sel_hi_pin(mode_sel_hi_pin),
    .mode_sel_lo_pin(mode_sel_lo_pin), .peakCfgWrite(peakCfgWrite), .peakCfgData(peakCfgData),
    .external_reference_select(external_reference_select), .phaseCurrents(phaseCurrents),
    .clock_in_pin(clock_in_pin), .extClockSelect(extClockSelect), .powerMode(powerMode),
    .funcEnables(funcEnables), .peak_detect_config(peak_detect_config),
    .regulatorsOn(regulatorsOn), .internalRefBufOn(internalRefBufOn),
    .inverted_clock_out(inverted_clock_out), .interrupt_out_a_n(interrupt_out_a_n),
    .interrupt_out_b_n(interrupt_out_b_n));
  host_pins hp (.want(want), .hiPin(mode_sel_hi_pin), .loPin(mode_sel_lo_pin));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input power_mode_t m, input int n);
    want = m;
    repeat (n) @(negedge clk);
  endtask : go
  task automatic wr(input logic [7:0] d, input logic e);
    {peakCfgData, external_reference_select, peakCfgWrite} = {d, e, 1'b1};
    @(negedge clk);
    peakCfgWrite = 0;
    @(negedge clk);
  endtask : wr
  task automatic tModes();
    for (int m = 0; m < 4; m++) begin
      go(power_mode_t'(m), 5);
      chk(powerMode, m[7:0]);
      chk(funcEnables, TAB[m]);
      chk(regulatorsOn, 1'b1);
    end
    go(idle_mode, 50);
    chk(regulatorsOn, 1'b0);
    go(full_operation_mode, 5);
    chk(regulatorsOn, 1'b1);
    $display("modes test done");
  endtask : tModes
  task automatic tCfg();
    wr(8'h12, 1'b1);
    chk(internalRefBufOn, 1'b0);
    wr(8'h02, 1'b0);
    chk(internalRefBufOn, 1'b1);
    go(peak_detect_mode, 5);
    wr(8'h55, 1'b0);
    chk(peak_detect_config, 8'h02);
    // Threshold 0x200: equal is quiet, one above trips, negative counts by size
    for (int i = 0; i < 3; i++) begin
      phaseCurrents = i == 1 ? {32'h0, 16'h0201} : {i == 2 ? 16'hfdff : 16'h0200, 32'h0};
      go(peak_detect_mode, 2);
      chk({interrupt_out_a_n, interrupt_out_b_n}, {i != 2, i != 1});
    end
    go(idle_mode, 5);
    chk({interrupt_out_a_n, interrupt_out_b_n}, 8'h03);
    chk(peak_detect_config, 8'h02);
    go(tamper_measure_mode, 5);
    chk(peak_detect_config, 8'h00);
    go(idle_mode, 5);
    chk(powerMode, 8'h03);
    $display("config test done");
  endtask : tCfg
  task automatic tClk();
    extClockSelect = 1;
    for (int i = 0; i < 3; i++) begin
      clock_in_pin = i[0];
      go(i == 2 ? peak_detect_mode : full_operation_mode, 5);
      chk(inverted_clock_out, i == 0);
    end
    extClockSelect = 0;
    go(full_operation_mode, 5);
    chk(inverted_clock_out, 1'b0);
    $display("clock test done");
  endtask : tClk
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tallyAndFinish
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    tModes();
    tCfg();
    tClk();
    tallyAndFinish();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      nMismatch++;
      tallyAndFinish();
    end
  end
endmodule : test_power_mode_controller
bind power_mode_controller mode_sva sva (
  .clk(clk), .sys_rst(sys_rst), .mode_sel_hi_pin(mode_sel_hi_pin),
  .mode_sel_lo_pin(mode_sel_lo_pin), .powerMode(powerMode), .funcEnables(funcEnables),
  .peak_detect_config(peak_detect_config), .regulatorsOn(regulatorsOn),
  .inverted_clock_out(inverted_clock_out), .interrupt_out_a_n(interrupt_out_a_n),
  .interrupt_out_b_n(interrupt_out_b_n));
`default_nettype wire
